// ==== common/sfr_pkg.sv ====
// shared constants and state types of the serial flash read path
`default_nettype none
package sfr_pkg;
  localparam int unsigned ADDR_W        = 24;
  localparam logic [23:0] ADDR_LAST     = 24'h0F_FFFF;
  localparam logic [7:0]  OPC_READ      = 8'h03;
  localparam logic [7:0]  OPC_FAST      = 8'h0B;
  localparam logic [7:0]  OPC_DUAL_OUT  = 8'h3B;
  localparam logic [7:0]  OPC_DUAL_IO   = 8'hBB;
  localparam logic [7:0]  OPC_MODE_RST  = 8'hFF;
  localparam logic [15:0] CONT_RST_BITS = 16'hFFFF;
  localparam logic [1:0]  CONT_SEL      = 2'b10;
  localparam int unsigned MODE_SEL_LSB  = 4;
  localparam logic [4:0]  OPC_CLKS      = 5'd8;
  localparam logic [4:0]  ADDR_CLKS_X1  = 5'd24;
  localparam logic [4:0]  ADDR_CLKS_X2  = 5'd12;
  localparam logic [4:0]  MODE_CLKS     = 5'd4;
  localparam logic [4:0]  DUMMY_CLKS    = 5'd8;
  localparam logic [4:0]  BYTE_CLKS_X1  = 5'd8;
  localparam logic [4:0]  BYTE_CLKS_X2  = 5'd4;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SCK_PERIOD_NS = 64;
  localparam int unsigned SCK_HALF_CLKS =
    SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned GAP_CLKS      = 4;
  typedef enum logic [2:0] {
    ST_OPC   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_MODE  = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA  = 3'b100,
    ST_IGN   = 3'b101
  } sfr_dev_st_t;
  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_OPC   = 3'b001,
    PH_ADDR  = 3'b010,
    PH_MODE  = 3'b011,
    PH_DUMMY = 3'b100,
    PH_DATA  = 3'b101,
    PH_GAP   = 3'b110
  } sfr_host_ph_t;
endpackage : sfr_pkg
`default_nettype wire

// ==== common/sfr_link_if.sv ====
// serial link between host controller and flash read path
`timescale 1ns/1ps
`default_nettype none
interface sfr_link_if;
  logic cs_n;
  logic sck;
  logic h_io0_o;
  logic h_io0_oe;
  logic h_io1_o;
  logic h_io1_oe;
  logic d_io0_o;
  logic d_io0_oe;
  logic d_io1_o;
  logic d_io1_oe;
  logic io0;
  logic io1;
  // undriven pins read as pulled high
  assign io0 = d_io0_oe ? d_io0_o : (h_io0_oe ? h_io0_o : 1'b1);
  assign io1 = d_io1_oe ? d_io1_o : (h_io1_oe ? h_io1_o : 1'b1);
  modport host (output cs_n, sck, h_io0_o, h_io0_oe, h_io1_o, h_io1_oe,
                input  io0, io1);
  modport dev  (input  cs_n, sck, io0, io1,
                output d_io0_o, d_io0_oe, d_io1_o, d_io1_oe);
endinterface : sfr_link_if
`default_nettype wire

// ==== rtl/sfr_flash_dev.sv ====
// flash side of the read path, clocked by the link clock
//
// Functional notes
// - read starts with opcode 03h/0Bh, 24-bit address
// - opcode 0Bh adds one dummy byte
// - address counter advances per output byte
// - single reads send msb first on SO
// - last location wraps to zero, no gap
// - chip select high ends read, SO released
// - opcode 3Bh, single-bit address, one dummy byte
// - dual data: 7,5 on SO; 6,4 on SI
// - chip select high releases SO and SI
// - opcode BBh, address and mode two bits/clock
// - dual-io data follows mode byte, no dummy
// - mode bits 5:4 = 10 skip next opcode
// - other mode bits restore full opcode decoding
// - mode low nibble is ignored
// - host releases pins on first data fall
// - mode reset command clears stored mode byte
// - dual-io address 12 clocks, mode 4 clocks
// - single opcode 8 clocks, address 24 clocks
`timescale 1ns/1ps
`default_nettype none
module sfr_flash_dev #(
  parameter logic [23:0] MEM_LAST = sfr_pkg::ADDR_LAST
) (
  sfr_link_if.dev               link,
  input  wire logic             srst_i,
  output logic [23:0]           mem_addr_o,
  input  wire logic [7:0]       mem_data_i,
  output logic                  cont_mode_o,
  output logic [7:0]            mode_byte_o
);
  ////////////////////////////////////////////////////////////////////////
  // frame state, cleared while chip select is high
  sfr_pkg::sfr_dev_st_t state_reg;
  sfr_pkg::sfr_dev_st_t state_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic [7:0]  opc_reg;
  logic [7:0]  mode_sh_reg;
  logic        started_reg;
  // persistent continuous-mode state
  logic        cont_reg;
  logic        cont_next;
  logic [7:0]  mode_reg;
  logic [7:0]  mode_next;
  // falling-edge output stage
  logic        drv_reg;
  logic        drv_x2_reg;
  logic        so_reg;
  logic        si_reg;

  ////////////////////////////////////////////////////////////////////////
  // a frame entered in continuous mode starts straight at the address
  wire skip_opc = cont_reg & ~started_reg;
  wire is_bb    = skip_opc | (opc_reg == sfr_pkg::OPC_DUAL_IO);
  wire is_3b    = ~skip_opc & (opc_reg == sfr_pkg::OPC_DUAL_OUT);
  wire is_0b    = ~skip_opc & (opc_reg == sfr_pkg::OPC_FAST);
  wire x2_addr  = is_bb;
  wire x2_data  = is_bb | is_3b;
  wire sfr_pkg::sfr_dev_st_t st_cur =
    skip_opc ? sfr_pkg::ST_ADDR : state_reg;

  wire [7:0]  opc_in   = {opc_reg[6:0], link.io0};
  wire [23:0] addr_x1  = {addr_reg[22:0], link.io0};
  wire [23:0] addr_x2  = {addr_reg[21:0], link.io1, link.io0};
  wire [23:0] addr_in  = x2_addr ? addr_x2 : addr_x1;
  wire [7:0]  mode_in  = {mode_sh_reg[5:0], link.io1, link.io0};
  wire [23:0] addr_inc =
    (addr_reg == MEM_LAST) ? 24'h00_0000 : addr_reg + 24'h00_0001;

  logic [4:0] ph_len;
  always_comb begin
    case (st_cur)
      sfr_pkg::ST_OPC:   ph_len = sfr_pkg::OPC_CLKS;
      sfr_pkg::ST_ADDR:  ph_len = x2_addr ? sfr_pkg::ADDR_CLKS_X2
                                          : sfr_pkg::ADDR_CLKS_X1;
      sfr_pkg::ST_MODE:  ph_len = sfr_pkg::MODE_CLKS;
      sfr_pkg::ST_DUMMY: ph_len = sfr_pkg::DUMMY_CLKS;
      sfr_pkg::ST_DATA:  ph_len = x2_data ? sfr_pkg::BYTE_CLKS_X2
                                          : sfr_pkg::BYTE_CLKS_X1;
      default:           ph_len = sfr_pkg::OPC_CLKS;
    endcase
  end
  wire ph_end = (cnt_reg == ph_len - 5'd1);

  // sixteen ones on the dual address pins leave continuous mode; cont_reg
  // is still set in the address phase only of an opcode-less frame
  wire cont_rst = cont_reg & (st_cur == sfr_pkg::ST_ADDR) &
                  (cnt_reg == 5'd7) &
                  (addr_x2[15:0] == sfr_pkg::CONT_RST_BITS);
  wire opc_rst  = (st_cur == sfr_pkg::ST_OPC) & ph_end &
                  (opc_in == sfr_pkg::OPC_MODE_RST);

  ////////////////////////////////////////////////////////////////////////
  // rising-edge command decode
  always_comb begin
    state_next = st_cur;
    cnt_next   = ph_end ? 5'd0 : cnt_reg + 5'd1;
    addr_next  = addr_reg;
    case (st_cur)
      sfr_pkg::ST_OPC: begin
        if (ph_end) begin
          case (opc_in)
            sfr_pkg::OPC_READ,
            sfr_pkg::OPC_FAST,
            sfr_pkg::OPC_DUAL_OUT,
            sfr_pkg::OPC_DUAL_IO: state_next = sfr_pkg::ST_ADDR;
            default:              state_next = sfr_pkg::ST_IGN;
          endcase
        end
      end
      sfr_pkg::ST_ADDR: begin
        addr_next = addr_in;
        if (cont_rst) begin
          state_next = sfr_pkg::ST_IGN;
        end else if (ph_end) begin
          if (is_bb) begin
            state_next = sfr_pkg::ST_MODE;
          end else if (is_0b | is_3b) begin
            state_next = sfr_pkg::ST_DUMMY;
          end else begin
            state_next = sfr_pkg::ST_DATA;
          end
        end
      end
      sfr_pkg::ST_MODE: begin
        if (ph_end) begin
          state_next = sfr_pkg::ST_DATA;
        end
      end
      sfr_pkg::ST_DUMMY: begin
        if (ph_end) begin
          state_next = sfr_pkg::ST_DATA;
        end
      end
      sfr_pkg::ST_DATA: begin
        if (ph_end) begin
          addr_next = addr_inc;
        end
      end
      default: begin
        cnt_next = cnt_reg;
      end
    endcase
  end

  // chip select high acts as the frame reset, so a frame ends even
  // mid-byte without any further clock edge
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      state_reg   <= sfr_pkg::ST_OPC;
      cnt_reg     <= 5'd0;
      addr_reg    <= 24'h00_0000;
      opc_reg     <= 8'h00;
      mode_sh_reg <= 8'h00;
      started_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      addr_reg    <= addr_next;
      started_reg <= 1'b1;
      if (st_cur == sfr_pkg::ST_OPC) begin
        opc_reg <= opc_in;
      end else if (skip_opc) begin
        // skip_opc lasts one edge only, the frame stays dual-io after it
        opc_reg <= sfr_pkg::OPC_DUAL_IO;
      end
      if (st_cur == sfr_pkg::ST_MODE) begin
        mode_sh_reg <= mode_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // continuous mode survives chip select; only a mode byte, a mode
  // reset or the link-side reset changes it
  always_comb begin
    cont_next = cont_reg;
    mode_next = mode_reg;
    if (opc_rst | cont_rst) begin
      cont_next = 1'b0;
      mode_next = 8'h00;
    end else if ((st_cur == sfr_pkg::ST_MODE) & ph_end) begin
      mode_next = mode_in;
      // only bits 5:4 decide, low nibble is don't care
      cont_next = (mode_in[sfr_pkg::MODE_SEL_LSB +: 2] ==
                   sfr_pkg::CONT_SEL);
    end else if ((st_cur == sfr_pkg::ST_OPC) & ph_end) begin
      cont_next = 1'b0;
    end
  end

  always_ff @(posedge link.sck) begin
    if (srst_i) begin
      cont_reg <= 1'b0;
      mode_reg <= 8'h00;
    end else begin
      cont_reg <= cont_next;
      mode_reg <= mode_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // falling-edge data out; the host has let go of the pins by then
  wire [2:0] bit_pos = cnt_reg[2:0];
  wire [2:0] hi_idx  = x2_data ? {~bit_pos[1:0], 1'b1} : ~bit_pos;
  wire [2:0] lo_idx  = {~bit_pos[1:0], 1'b0};
  wire       in_data = (st_cur == sfr_pkg::ST_DATA);

  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      drv_reg    <= 1'b0;
      drv_x2_reg <= 1'b0;
      so_reg     <= 1'b0;
      si_reg     <= 1'b0;
    end else begin
      drv_reg    <= in_data;
      drv_x2_reg <= in_data & x2_data;
      so_reg     <= mem_data_i[hi_idx];
      si_reg     <= mem_data_i[lo_idx];
    end
  end

  // enables also gated by chip select so the pins float at once
  assign link.d_io1_o  = so_reg;
  assign link.d_io1_oe = drv_reg & ~link.cs_n;
  assign link.d_io0_o  = si_reg;
  assign link.d_io0_oe = drv_x2_reg & ~link.cs_n;

  assign mem_addr_o  = addr_reg;
  assign cont_mode_o = cont_reg;
  assign mode_byte_o = mode_reg;
endmodule : sfr_flash_dev
`default_nettype wire

// ==== rtl/sfr_flash_host.sv ====
// host controller end: makes the link clock and runs read commands
`timescale 1ns/1ps
`default_nettype none
module sfr_flash_host #(
  parameter int unsigned HALF_CLKS = sfr_pkg::SCK_HALF_CLKS,
  parameter int unsigned GAP_CLKS  = sfr_pkg::GAP_CLKS
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  sfr_link_if.host         link,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  cmd_opcode_i,
  input  wire logic [23:0] cmd_addr_i,
  input  wire logic [7:0]  cmd_mode_i,
  input  wire logic        cmd_skip_opc_i,
  input  wire logic [15:0] cmd_len_i,
  output logic [7:0]       rd_data_o,
  output logic             rd_valid_o,
  output logic             busy_o
);
  ////////////////////////////////////////////////////////////////////////
  sfr_pkg::sfr_host_ph_t ph_reg;
  logic [39:0] tx_reg;
  logic [4:0]  cnt_reg;
  logic [15:0] len_reg;
  logic [7:0]  op_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  data_reg;
  logic        valid_reg;
  logic        done_reg;
  logic        sck_reg;
  logic        cs_n_reg;
  logic [7:0]  div_reg;
  logic [1:0]  s1_reg;
  logic [1:0]  s2_reg;
  logic [1:0]  s3_reg;
  logic [1:0]  in_reg;

  ////////////////////////////////////////////////////////////////////////
  // pins from the far end: three flops, a change counts once the
  // last two agree
  wire [1:0] agree   = s2_reg ~^ s3_reg;
  wire [1:0] in_next = (agree & s2_reg) | (~agree & in_reg);

  wire is_bb   = (op_reg == sfr_pkg::OPC_DUAL_IO);
  wire is_3b   = (op_reg == sfr_pkg::OPC_DUAL_OUT);
  wire is_0b   = (op_reg == sfr_pkg::OPC_FAST);
  wire is_03   = (op_reg == sfr_pkg::OPC_READ);
  wire x2_data = is_bb | is_3b;
  wire x2_tx   = ((ph_reg == sfr_pkg::PH_ADDR) & is_bb) |
                 (ph_reg == sfr_pkg::PH_MODE);
  wire tick    = (div_reg == 8'(HALF_CLKS - 1));
  wire rise    = tick & ~sck_reg;
  wire fall    = tick & sck_reg;
  wire sending = (ph_reg == sfr_pkg::PH_OPC) |
                 (ph_reg == sfr_pkg::PH_ADDR) |
                 (ph_reg == sfr_pkg::PH_MODE) |
                 (ph_reg == sfr_pkg::PH_DUMMY);

  logic [4:0] ph_len;
  always_comb begin
    case (ph_reg)
      sfr_pkg::PH_OPC:   ph_len = sfr_pkg::OPC_CLKS;
      sfr_pkg::PH_ADDR:  ph_len = is_bb ? sfr_pkg::ADDR_CLKS_X2
                                        : sfr_pkg::ADDR_CLKS_X1;
      sfr_pkg::PH_MODE:  ph_len = sfr_pkg::MODE_CLKS;
      sfr_pkg::PH_DUMMY: ph_len = sfr_pkg::DUMMY_CLKS;
      default:           ph_len = x2_data ? sfr_pkg::BYTE_CLKS_X2
                                          : sfr_pkg::BYTE_CLKS_X1;
    endcase
  end

  wire to_data = (len_reg == 16'h0000);
  sfr_pkg::sfr_host_ph_t ph_after;
  always_comb begin
    case (ph_reg)
      sfr_pkg::PH_OPC:
        ph_after = (is_bb | is_3b | is_0b | is_03) ? sfr_pkg::PH_ADDR
                                                   : sfr_pkg::PH_GAP;
      sfr_pkg::PH_ADDR:
        ph_after = is_bb ? sfr_pkg::PH_MODE :
                   (is_0b | is_3b) ? sfr_pkg::PH_DUMMY :
                   to_data ? sfr_pkg::PH_GAP : sfr_pkg::PH_DATA;
      default:
        ph_after = to_data ? sfr_pkg::PH_GAP : sfr_pkg::PH_DATA;
    endcase
  end

  wire [7:0] rx_x1 = {rx_reg[6:0], in_next[1]};
  wire [7:0] rx_x2 = {rx_reg[5:0], in_next[1], in_next[0]};
  wire [7:0] rx_in = x2_data ? rx_x2 : rx_x1;
  wire       byte_end = (cnt_reg == ph_len - 5'd1);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    s1_reg <= {link.io1, link.io0};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
    in_reg <= in_next;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ph_reg    <= sfr_pkg::PH_IDLE;
      tx_reg    <= 40'h00_0000_0000;
      cnt_reg   <= 5'd0;
      len_reg   <= 16'h0000;
      op_reg    <= 8'h00;
      rx_reg    <= 8'h00;
      data_reg  <= 8'h00;
      valid_reg <= 1'b0;
      done_reg  <= 1'b0;
      sck_reg   <= 1'b0;
      cs_n_reg  <= 1'b1;
      div_reg   <= 8'h00;
    end else begin
      valid_reg <= 1'b0;
      div_reg   <= (tick | (ph_reg == sfr_pkg::PH_IDLE)) ? 8'h00
                                                         : div_reg + 8'h01;
      case (ph_reg)
        sfr_pkg::PH_IDLE: begin
          done_reg <= 1'b0;
          cnt_reg  <= 5'd0;
          if (cmd_valid_i) begin
            cs_n_reg <= 1'b0;
            len_reg  <= cmd_len_i;
            // skipping the opcode means a continuous dual-io frame
            op_reg   <= cmd_skip_opc_i ? sfr_pkg::OPC_DUAL_IO
                                       : cmd_opcode_i;
            ph_reg   <= cmd_skip_opc_i ? sfr_pkg::PH_ADDR
                                       : sfr_pkg::PH_OPC;
            tx_reg   <= cmd_skip_opc_i
                        ? {cmd_addr_i, cmd_mode_i, 8'h00}
                        : {cmd_opcode_i, cmd_addr_i, cmd_mode_i};
          end
        end
        sfr_pkg::PH_GAP: begin
          cs_n_reg <= 1'b1;
          sck_reg  <= 1'b0;
          if (div_reg == 8'(GAP_CLKS - 1)) begin
            ph_reg <= sfr_pkg::PH_IDLE;
          end
        end
        default: begin
          if (rise) begin
            sck_reg <= 1'b1;
            cnt_reg <= cnt_reg + 5'd1;
            if (ph_reg == sfr_pkg::PH_DATA) begin
              rx_reg <= rx_in;
              if (byte_end) begin
                cnt_reg   <= 5'd0;
                data_reg  <= rx_in;
                valid_reg <= 1'b1;
                len_reg   <= len_reg - 16'h0001;
                done_reg  <= (len_reg == 16'h0001);
              end
            end
          end else if (fall) begin
            sck_reg <= 1'b0;
            if (done_reg) begin
              ph_reg   <= sfr_pkg::PH_GAP;
              cs_n_reg <= 1'b1;
            end else if (sending) begin
              tx_reg <= x2_tx ? {tx_reg[37:0], 2'b00}
                              : {tx_reg[38:0], 1'b0};
              if (cnt_reg == ph_len) begin
                cnt_reg <= 5'd0;
                ph_reg  <= ph_after;
                cs_n_reg <= (ph_after == sfr_pkg::PH_GAP);
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins drop as the data phase begins, on the falling edge that
  // starts the first data clock
  assign link.cs_n     = cs_n_reg;
  assign link.sck      = sck_reg;
  assign link.h_io0_o  = x2_tx ? tx_reg[38] : tx_reg[39];
  assign link.h_io0_oe = sending;
  assign link.h_io1_o  = tx_reg[39];
  assign link.h_io1_oe = sending & x2_tx;
  assign cmd_ready_o   = (ph_reg == sfr_pkg::PH_IDLE);
  assign busy_o        = (ph_reg != sfr_pkg::PH_IDLE);
  assign rd_data_o     = data_reg;
  assign rd_valid_o    = valid_reg;
endmodule : sfr_flash_host
`default_nettype wire

// ==== tb/sfr_link_monitor.sv ====
// concurrent checks on the link between host and flash ends
`timescale 1ns/1ps
`default_nettype none
module sfr_link_monitor (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic h_io0_o,
  input wire logic h_io0_oe,
  input wire logic h_io1_o,
  input wire logic h_io1_oe,
  input wire logic d_io0_o,
  input wire logic d_io0_oe,
  input wire logic d_io1_o,
  input wire logic d_io1_oe
);
  ////////////////////////////////////////////////////////////////////////////
  logic       sck_reg;
  logic [7:0] rise_cnt_reg;
  logic [7:0] rise_cnt_next;
  wire        sck_rise;

  // rising edges counted per frame; cleared while deselected
  assign sck_rise      = sck & ~sck_reg;
  assign rise_cnt_next = (srst_i || cs_n) ? 8'h00 :
                         (sck_rise ? rise_cnt_reg + 8'h01 : rise_cnt_reg);

  always_ff @(posedge clock_i) begin
    sck_reg      <= sck;
    rise_cnt_reg <= rise_cnt_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // header length: 16 skip, 24 dual-io, 32 plain, 40 with dummy byte
  sequence data_start_s;
    $rose(d_io1_oe);
  endsequence

  property data_lead_p;
    data_start_s |-> $fell(sck) && (rise_cnt_reg inside
      {8'h10, 8'h18, 8'h20, 8'h28});
  endproperty

  chk_cs_release: assert property (
    cs_n |-> !d_io0_oe && !d_io1_oe)
    else $error("device drives a pin while deselected");
  chk_dual_release: assert property (
    $rose(cs_n) |-> !d_io0_oe && !d_io1_oe ##1 !d_io0_oe && !d_io1_oe)
    else $error("dual pins not released after deselect");
  chk_pin_turnaround: assert property (
    !(d_io0_oe && h_io0_oe) && !(d_io1_oe && h_io1_oe))
    else $error("host and device drive one pin together");
  chk_dual_pair: assert property (
    d_io0_oe |-> d_io1_oe)
    else $error("second data pin driven without the first");
  chk_data_lead: assert property (data_lead_p)
    else $error("first data bit after wrong clock count");
  chk_drive_fall: assert property (
    ($changed(d_io1_o) && d_io1_oe && $past(d_io1_oe)) ||
    ($changed(d_io0_o) && d_io0_oe && $past(d_io0_oe)) |-> $fell(sck))
    else $error("device output changed off a falling edge");
  chk_host_shift: assert property (
    ($changed(h_io0_o) && h_io0_oe && $past(h_io0_oe)) ||
    ($changed(h_io1_o) && h_io1_oe && $past(h_io1_oe)) |-> !sck)
    else $error("host output changed while clock high");
  chk_sck_high: assert property (
    $rose(sck) |-> sck [*4] ##1 !sck)
    else $error("link clock high phase of wrong length");
  chk_frame_idle: assert property (
    cs_n |-> !sck)
    else $error("link clock not idle low outside a frame");
endmodule : sfr_link_monitor
`default_nettype wire

// ==== tb/serial_flash_read_path_bench.sv ====
// self-checking bench joining the host and flash ends over the link
`timescale 1ns/1ps
`default_nettype none
module serial_flash_read_path_bench;
  typedef struct {
    logic [7:0]  opc;
    logic [23:0] adr;
    logic [7:0]  mode;
    logic        skip;
    logic [15:0] len;
    logic        cont;
  } sfr_case_t;

  localparam int LIMIT = 20000;

  logic        clk, srst, dev_srst, cmd_valid, cmd_ready, cmd_skip;
  logic        rd_valid, busy, cont_mode;
  logic [7:0]  cmd_opc, cmd_mode, rd_data, mem_data, mode_byte;
  logic [23:0] cmd_adr, mem_addr;
  logic [15:0] cmd_len;
  int          error_cnt, n_compared, cyc;
  sfr_case_t   cases [12];

  ////////////////////////////////////////////////////////////////////////////
  sfr_link_if link ();

  sfr_flash_host i_sfr_flash_host (
    .clock_i(clk), .srst_i(srst), .link(link),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_opcode_i(cmd_opc), .cmd_addr_i(cmd_adr), .cmd_mode_i(cmd_mode),
    .cmd_skip_opc_i(cmd_skip), .cmd_len_i(cmd_len),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .busy_o(busy));

  sfr_flash_dev i_sfr_flash_dev (
    .link(link), .srst_i(dev_srst), .mem_addr_o(mem_addr),
    .mem_data_i(mem_data), .cont_mode_o(cont_mode),
    .mode_byte_o(mode_byte));

  sfr_link_monitor i_sfr_link_monitor (
    .clock_i(clk), .srst_i(srst), .cs_n(link.cs_n), .sck(link.sck),
    .h_io0_o(link.h_io0_o), .h_io0_oe(link.h_io0_oe),
    .h_io1_o(link.h_io1_o), .h_io1_oe(link.h_io1_oe),
    .d_io0_o(link.d_io0_o), .d_io0_oe(link.d_io0_oe),
    .d_io1_o(link.d_io1_o), .d_io1_oe(link.d_io1_oe));

  ////////////////////////////////////////////////////////////////////////////
  // memory contents differ between neighbours and across the wrap point
  function automatic logic [7:0] mem_fn(input logic [23:0] a);
    return a[7:0] ^ a[23:16] ^ 8'h5A;
  endfunction : mem_fn

  assign mem_data = mem_fn(mem_addr);

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic run_cmd(input sfr_case_t c);
    int          n;
    int          g;
    logic [23:0] a;
    n = 0;
    g = 0;
    while (cmd_ready !== 1'b1 && g < 200) begin
      @(negedge clk);
      g++;
    end
    cmd_opc   = c.opc;
    cmd_adr   = c.adr;
    cmd_mode  = c.mode;
    cmd_skip  = c.skip;
    cmd_len   = c.len;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    g = 0;
    while (n < int'(c.len) && g < 4000) begin
      @(negedge clk);
      g++;
      if (rd_valid === 1'b1) begin
        a = c.adr + 24'(n);
        if (a > sfr_pkg::ADDR_LAST) begin
          a = a - sfr_pkg::ADDR_LAST - 24'h00_0001;
        end
        check({16'h0000, rd_data}, {16'h0000, mem_fn(a)});
        n++;
      end
    end
    check(24'(n), {8'h00, c.len});
    g = 0;
    while (busy !== 1'b0 && g < 400) begin
      @(negedge clk);
      g++;
    end
    check({23'h00_0000, busy}, 24'h00_0000);
    check({23'h00_0000, cont_mode}, {23'h00_0000, c.cont});
    if (c.opc == sfr_pkg::OPC_DUAL_IO && !c.skip) begin
      check({16'h0000, mode_byte}, {16'h0000, c.mode});
    end
  endtask : run_cmd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("Error at %0t ns: run did not finish in time", $time);
      end_sim;
    end
  end

  initial begin
    srst       = 1'b1;
    dev_srst   = 1'b1;
    cmd_valid  = 1'b0;
    cmd_opc    = 8'h00;
    cmd_adr    = 24'h00_0000;
    cmd_mode   = 8'h00;
    cmd_skip   = 1'b0;
    cmd_len    = 16'h0000;
    error_cnt  = 0;
    n_compared = 0;
    cyc        = 0;
    // flash end resets only while the host clocks a frame
    cases[0]  = '{8'hFF, 24'h00_0000, 8'h00, 1'b0, 16'h0000, 1'b0};
    cases[1]  = '{8'h03, 24'h00_1230, 8'h00, 1'b0, 16'h0003, 1'b0};
    cases[2]  = '{8'h0B, 24'h0A_BCDE, 8'h00, 1'b0, 16'h0002, 1'b0};
    cases[3]  = '{8'h03, 24'h0F_FFFE, 8'h00, 1'b0, 16'h0004, 1'b0};
    cases[4]  = '{8'h3B, 24'h0F_FFFF, 8'h00, 1'b0, 16'h0003, 1'b0};
    cases[5]  = '{8'hBB, 24'h01_2345, 8'h2F, 1'b0, 16'h0002, 1'b1};
    cases[6]  = '{8'hBB, 24'h0F_0F00, 8'h20, 1'b1, 16'h0002, 1'b1};
    cases[7]  = '{8'hBB, 24'h0F_FFFF, 8'h1F, 1'b1, 16'h0002, 1'b0};
    cases[8]  = '{8'hBB, 24'h00_0010, 8'hE5, 1'b0, 16'h0001, 1'b1};
    cases[9]  = '{8'hBB, 24'hFF_FF00, 8'h00, 1'b1, 16'h0000, 1'b0};
    cases[10] = '{8'h03, 24'h00_0000, 8'h00, 1'b0, 16'h0001, 1'b0};
    cases[11] = '{8'h0B, 24'h0F_FFFF, 8'h00, 1'b0, 16'h0002, 1'b0};
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      run_cmd(cases[i]);
      dev_srst = 1'b0;
      $display("test %0d done, opcode %0h", i, cases[i].opc);
    end
    end_sim;
  end
endmodule : serial_flash_read_path_bench
`default_nettype wire
